/* core/dsp_pkg.sv */
// package with constants and types for the dual-slope pwm timer
// ****************************************************************
// Summary of operation
// - phase correct modes 1,2,3 use fixed top 0x00FF, 0x01FF, 0x03FF
// - phase correct mode 10 tops at capture value, mode 11 at compare a
// - variable top works from 0x0003 up to 0xFFFF
// - counter runs up from zero to top, then down to zero
// - counter reverses at top and holds top one timer cycle
// - phase correct mode sets overflow flag at every bottom
// - phase correct loads compares at top; top source flag set there too
// - channel compare flag set on a timer tick when count equals active compare value
// - with fixed top, compare writes clear bits above the resolution
// - mode 2 clears on up match, sets on down match; mode 3 inverts
// - compare waveform reaches pin only when direction bit selects output
// - mode 2 compare at bottom gives constant low, at top constant high
// - mode 11 with output mode 1 toggles channel a, half duty
// - frequency correct mode 8 tops at capture value, mode 9 at compare a
// - frequency correct loads compares at bottom with overflow flag
// - frequency correct sets top source flag when count reaches top
// - mode 9 with output mode 1 toggles channel a, half duty
// - timer enable comes from prescaler of 1, 8, 64, 256 or 1024
// - output mode 0 leaves pin under normal port control
// - output mode 1 toggles only channel a in modes 9 or 11
// ****************************************************************
package dsp_pkg;
  localparam int          CNT_W       = 16;
  localparam int          NUM_CH      = 3;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [15:0] CAP_RST     = 16'h0000;
  localparam logic [3:0]  WGM_PC8     = 4'h1;
  localparam logic [3:0]  WGM_PC9     = 4'h2;
  localparam logic [3:0]  WGM_PC10    = 4'h3;
  localparam logic [3:0]  WGM_PFC_CAP = 4'h8;
  localparam logic [3:0]  WGM_PFC_CMA = 4'h9;
  localparam logic [3:0]  WGM_PC_CAP  = 4'hA;
  localparam logic [3:0]  WGM_PC_CMA  = 4'hB;
  localparam logic [1:0]  COM_OFF     = 2'h0;
  localparam logic [1:0]  COM_TOGGLE  = 2'h1;
  localparam logic [1:0]  COM_NONINV  = 2'h2;
  localparam logic [1:0]  COM_INV     = 2'h3;
  localparam logic [2:0]  PRE_STOP    = 3'h0;
  localparam logic [2:0]  PRE_DIV1    = 3'h1;
  localparam logic [2:0]  PRE_DIV8    = 3'h2;
  localparam logic [2:0]  PRE_DIV64   = 3'h3;
  localparam logic [2:0]  PRE_DIV256  = 3'h4;
  localparam logic [2:0]  PRE_DIV1024 = 3'h5;
  localparam logic [9:0]  DIV8_LAST    = 10'h007;
  localparam logic [9:0]  DIV64_LAST   = 10'h03F;
  localparam logic [9:0]  DIV256_LAST  = 10'h0FF;
  localparam logic [9:0]  DIV1024_LAST = 10'h3FF;
  localparam logic [15:0] ADDR_CTRL   = 16'h0000;
  localparam logic [15:0] ADDR_CMP_A  = 16'h0004;
  localparam logic [15:0] ADDR_CMP_B  = 16'h0008;
  localparam logic [15:0] ADDR_CMP_C  = 16'h000C;
  localparam logic [15:0] ADDR_CAP    = 16'h0010;
  localparam logic [15:0] ADDR_CNT    = 16'h0014;
  localparam logic [15:0] ADDR_FLAGS  = 16'h0018;
  localparam logic [15:0] ADDR_DIR    = 16'h001C;
  localparam int          F_OVF       = 0;
  localparam int          F_CAP       = 1;
  localparam int          F_CMP0      = 2;

  typedef enum logic [0:0] {
    DSP_UP   = 1'b0,
    DSP_DOWN = 1'b1
  } dsp_dir_e;

  // control word: com c,b,a; prescale; waveform mode
  typedef struct packed {
    logic [1:0] com_c;
    logic [1:0] com_b;
    logic [1:0] com_a;
    logic [2:0] clk_sel;
    logic [3:0] waveform_mode_select;
  } dsp_ctrl_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } dsp_bus_s;
endpackage : dsp_pkg

/* core/dsp_timer.sv */
// dual-slope pwm timer core with register port
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dsp_timer
  import dsp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire dsp_bus_s          bus,
  output logic [15:0]            rdata,
  input  wire logic [NUM_CH-1:0] port_out,
  output logic [NUM_CH-1:0]      pin_out,
  output logic [NUM_CH-1:0]      pin_oe_n,
  output logic [15:0]            count_value,
  output logic [NUM_CH-1:0]      compare_output,
  output logic                   overflow_flag,
  output logic                   capture_flag,
  output logic [NUM_CH-1:0]      compare_flag,
  output logic                   timer_tick
);
  // ****************************************************************
  // registers
  // ****************************************************************
  dsp_ctrl_s         ctrl;
  logic [15:0]       cmp_buf [NUM_CH];
  logic [15:0]       cmp_act [NUM_CH];
  logic [15:0]       capture_top_value;
  logic [NUM_CH-1:0] pin_direction_bit;
  dsp_dir_e          dir;
  logic [9:0]        pre_cnt;
  logic [15:0]       top;
  logic [15:0]       fix_mask;
  logic              fixed_top;
  logic              pfc_mode;
  logic              pc_mode;
  logic              run;
  logic              at_top;
  logic              at_bot;
  logic              cnt_wr;
  logic              up_slope;
  logic [15:0]       next_count;
  logic [1:0]        com [NUM_CH];

  assign com[0] = ctrl.com_a;
  assign com[1] = ctrl.com_b;
  assign com[2] = ctrl.com_c;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  always_comb begin
    fixed_top = 1'b1;
    fix_mask  = 16'hFFFF;
    top       = TOP_8BIT;
    case (ctrl.waveform_mode_select)
      WGM_PC8: begin
        top      = TOP_8BIT;
        fix_mask = TOP_8BIT;
      end
      WGM_PC9: begin
        top      = TOP_9BIT;
        fix_mask = TOP_9BIT;
      end
      WGM_PC10: begin
        top      = TOP_10BIT;
        fix_mask = TOP_10BIT;
      end
      WGM_PC_CAP, WGM_PFC_CAP: begin
        fixed_top = 1'b0;
        top       = capture_top_value;
      end
      WGM_PC_CMA, WGM_PFC_CMA: begin
        fixed_top = 1'b0;
        top       = cmp_act[0];
      end
      default: begin
        fixed_top = 1'b0;
      end
    endcase
  end

  assign pfc_mode = (ctrl.waveform_mode_select == WGM_PFC_CAP)
                 || (ctrl.waveform_mode_select == WGM_PFC_CMA);
  assign pc_mode  = (ctrl.waveform_mode_select == WGM_PC8)
                 || (ctrl.waveform_mode_select == WGM_PC9)
                 || (ctrl.waveform_mode_select == WGM_PC10)
                 || (ctrl.waveform_mode_select == WGM_PC_CAP)
                 || (ctrl.waveform_mode_select == WGM_PC_CMA);
  assign run    = (pc_mode || pfc_mode) && timer_tick;
  assign at_top = (count_value == top);
  assign at_bot = (count_value == CNT_BOTTOM);
  assign cnt_wr = bus.wr && (bus.addr == ADDR_CNT);
  assign up_slope = at_bot || (dir == DSP_UP && !at_top);

  // ****************************************************************
  // prescaler
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 10'h000;
    end else if (ctrl.clk_sel == PRE_STOP) begin
      pre_cnt <= 10'h000;
    end else begin
      pre_cnt <= pre_cnt + 10'h001;
    end
  end

  always_comb begin
    case (ctrl.clk_sel)
      PRE_DIV1:    timer_tick = 1'b1;
      PRE_DIV8:    timer_tick = (pre_cnt[2:0] == DIV8_LAST[2:0]);
      PRE_DIV64:   timer_tick = (pre_cnt[5:0] == DIV64_LAST[5:0]);
      PRE_DIV256:  timer_tick = (pre_cnt[7:0] == DIV256_LAST[7:0]);
      PRE_DIV1024: timer_tick = (pre_cnt == DIV1024_LAST);
      default:     timer_tick = 1'b0;
    endcase
  end

  // ****************************************************************
  // counter and direction
  // ****************************************************************
  // a top below the count lets the counter run on to wrap, as software
  // was warned; the match at top then comes on the next pass
  always_comb begin
    if (dir == DSP_UP) begin
      next_count = at_top ? count_value - 16'h0001 : count_value + 16'h0001;
    end else begin
      next_count = at_bot ? count_value + 16'h0001 : count_value - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= CNT_RST;
      dir         <= DSP_UP;
    end else if (cnt_wr) begin
      count_value <= bus.wdata;
    end else if (run) begin
      count_value <= next_count;
      if (dir == DSP_UP && at_top) begin
        dir <= DSP_DOWN;
      end else if (dir == DSP_DOWN && at_bot) begin
        dir <= DSP_UP;
      end
    end
  end

  // ****************************************************************
  // register writes and double buffer
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl              <= '0;
      capture_top_value <= CAP_RST;
      pin_direction_bit <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_CTRL: ctrl              <= dsp_ctrl_s'(bus.wdata[12:0]);
        ADDR_CAP:  capture_top_value <= bus.wdata;
        ADDR_DIR:  pin_direction_bit <= bus.wdata[NUM_CH-1:0];
        default:   ctrl              <= ctrl;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [15:0] ADDR_ME = ADDR_CMP_A + 16'(4 * gi);
      logic load;
      logic match;
      logic oc;
      assign load  = run && (pfc_mode ? at_bot : at_top);
      assign match = (count_value == cmp_act[gi]);

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cmp_buf[gi] <= CMP_RST;
        end else if (bus.wr && bus.addr == ADDR_ME) begin
          cmp_buf[gi] <= fixed_top ? (bus.wdata & fix_mask)
                                   : bus.wdata;
        end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cmp_act[gi] <= CMP_RST;
        end else if (load) begin
          cmp_act[gi] <= cmp_buf[gi];
        end
      end

      // hardware set wins over a software clear in the same cycle
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          compare_flag[gi] <= 1'b0;
        end else if (run && match) begin
          compare_flag[gi] <= 1'b1;
        end else if (bus.wr && bus.addr == ADDR_FLAGS
                     && bus.wdata[F_CMP0 + gi]) begin
          compare_flag[gi] <= 1'b0;
        end
      end

      // a match at top acts as falling and at bottom as rising, so a
      // compare at either end holds the level: that gives the extremes
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          oc <= 1'b0;
        end else if (run && match) begin
          case (com[gi])
            COM_NONINV: oc <= !up_slope;
            COM_INV:    oc <= up_slope;
            COM_TOGGLE: begin
              if (gi == 0 && (ctrl.waveform_mode_select == WGM_PC_CMA
                  || ctrl.waveform_mode_select == WGM_PFC_CMA)) begin
                oc <= ~oc;
              end
            end
            default:    oc <= oc;
          endcase
        end
      end
      assign compare_output[gi] = oc;

      // pin mux: compare drives the pin only when connected and output
      logic connected;
      assign connected = (com[gi] == COM_NONINV) || (com[gi] == COM_INV)
                      || (com[gi] == COM_TOGGLE && gi == 0
                          && (ctrl.waveform_mode_select == WGM_PC_CMA
                          || ctrl.waveform_mode_select == WGM_PFC_CMA));
      assign pin_out[gi]  = connected ? oc : port_out[gi];
      assign pin_oe_n[gi] = ~pin_direction_bit[gi];
    end
  endgenerate

  // ****************************************************************
  // overflow and capture flags
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (run && at_bot) begin
      overflow_flag <= 1'b1;
    end else if (bus.wr && bus.addr == ADDR_FLAGS && bus.wdata[F_OVF]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      capture_flag <= 1'b0;
    end else if (run && at_top && (ctrl.waveform_mode_select == WGM_PC_CAP
                 || ctrl.waveform_mode_select == WGM_PFC_CAP)) begin
      capture_flag <= 1'b1;
    end else if (bus.wr && bus.addr == ADDR_FLAGS && bus.wdata[F_CAP]) begin
      capture_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL:  rdata <= {3'h0, ctrl};
        ADDR_CMP_A: rdata <= cmp_buf[0];
        ADDR_CMP_B: rdata <= cmp_buf[1];
        ADDR_CMP_C: rdata <= cmp_buf[2];
        ADDR_CAP:   rdata <= capture_top_value;
        ADDR_CNT:   rdata <= count_value;
        ADDR_FLAGS: rdata <= {11'h000, compare_flag, capture_flag,
                              overflow_flag};
        ADDR_DIR:   rdata <= {13'h0000, pin_direction_bit};
        default:    rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_fixed_top;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctrl.waveform_mode_select == WGM_PC8) |-> (count_value <= TOP_8BIT
        || $past(ctrl.waveform_mode_select) != WGM_PC8);
  endproperty
  a_fixed_top: assert property (p_fixed_top)
    else $error("count above fixed top");

  property p_reverse;
    @(posedge clk_sys) disable iff (!rst_n)
      (run && at_top && dir == DSP_UP && !cnt_wr) |=> (dir == DSP_DOWN);
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("no reversal at top");

  property p_step;
    @(posedge clk_sys) disable iff (!rst_n)
      (run && !cnt_wr && !at_top && !at_bot && dir == DSP_UP)
        |=> (count_value == $past(count_value) + 16'h0001);
  endproperty
  a_step: assert property (p_step)
    else $error("up count did not step");

  property p_ovf;
    @(posedge clk_sys) disable iff (!rst_n)
      (run && at_bot) |=> overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag missed at bottom");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (!run && !cnt_wr) |=> $stable(count_value);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved without tick");

  property p_pfc_load;
    @(posedge clk_sys) disable iff (!rst_n)
      (run && pfc_mode && !at_bot) |=> $stable(cmp_act[1]);
  endproperty
  a_pfc_load: assert property (p_pfc_load)
    else $error("compare loaded away from bottom");

  property p_cmp_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      (run && count_value == cmp_act[1]) |=> compare_flag[1];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("compare flag missed");

  property p_noninv;
    @(posedge clk_sys) disable iff (!rst_n)
      (run && ctrl.com_a == COM_NONINV && count_value == cmp_act[0]
       && dir == DSP_UP && !at_top) |=> !compare_output[0];
  endproperty
  a_noninv: assert property (p_noninv)
    else $error("output not cleared on up match");

  property p_pin_oe;
    @(posedge clk_sys) disable iff (!rst_n)
      (bus.wr && bus.addr == ADDR_DIR)
        |=> (pin_oe_n[1] == !$past(bus.wdata[1]));
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin enable does not follow direction");

  c_top:    cover property (@(posedge clk_sys) run && at_top && dir == DSP_UP);
  c_bottom: cover property (@(posedge clk_sys) run && at_bot && pfc_mode);
  c_toggle: cover property (@(posedge clk_sys) run && ctrl.com_a == COM_TOGGLE
                            && count_value == cmp_act[0]);
endmodule : dsp_timer
`default_nettype wire

/* verif/dsp_timer_bench.sv */
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/100ps
`default_nettype none
module dsp_timer_bench
  import dsp_pkg::*;
;
  // ****************************************************************
  // signals and instance
  // ****************************************************************
  typedef struct packed {
    logic [3:0]  m;
    logic [15:0] cap;
    logic [15:0] top;
    logic [15:0] mask;
    logic        fc;
    logic        fa;
  } dsp_row_s;

  // compare a buffer holds 16'h0020 through all rows
  localparam dsp_row_s ROWS [7] = '{
    '{WGM_PC8, 16'h0000, TOP_8BIT, TOP_8BIT, 1'h0, 1'h1},
    '{WGM_PC9, 16'h0000, TOP_9BIT, TOP_9BIT, 1'h0, 1'h1},
    '{WGM_PC10, 16'h0000, TOP_10BIT, TOP_10BIT, 1'h0, 1'h1},
    '{WGM_PC_CAP, 16'h0003, 16'h0003, 16'hFFFF, 1'h1, 1'h0},
    '{WGM_PC_CMA, 16'h0003, 16'h0020, 16'hFFFF, 1'h0, 1'h1},
    '{WGM_PFC_CAP, 16'h0040, 16'h0040, 16'hFFFF, 1'h1, 1'h1},
    '{WGM_PFC_CMA, 16'h0040, 16'h0020, 16'hFFFF, 1'h0, 1'h1}
  };
  localparam int TICKS [6] = '{0, 2048, 256, 32, 8, 2};

  logic        clk_sys  = 1'h0;
  logic        rst_n    = 1'h0;
  dsp_bus_s    bus      = '0;
  logic [2:0]  port_out = 3'h5;
  logic [15:0] rdata;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe_n;
  logic [15:0] count_value;
  logic [2:0]  compare_output;
  logic        overflow_flag;
  logic        capture_flag;
  logic [2:0]  compare_flag;
  logic        timer_tick;
  int          failures = 0;
  int          compares = 0;
  logic [15:0] d, mx, prev, dif;
  int          bad, hi_a, hi_b, tk;
  logic        ptk;

  always #5 clk_sys = ~clk_sys;

  dsp_timer dut_u (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .bus            (bus),
    .rdata          (rdata),
    .port_out       (port_out),
    .pin_out        (pin_out),
    .pin_oe_n       (pin_oe_n),
    .count_value    (count_value),
    .compare_output (compare_output),
    .overflow_flag  (overflow_flag),
    .capture_flag   (capture_flag),
    .compare_flag   (compare_flag),
    .timer_tick     (timer_tick)
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask : cyc

  // strobes drop at the next edge, so a following call leaves one idle cycle
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    bus <= '{a, v, 1'h1, 1'h0};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    bus <= '{a, 16'h0000, 1'h0, 1'h1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    v = rdata;
  endtask : rd

  function automatic logic [15:0] cw(input logic [1:0] a, input logic [1:0] b,
                                     input logic [1:0] c, input logic [2:0] s,
                                     input logic [3:0] m);
    cw = {3'h0, c, b, a, s, m};
  endfunction : cw

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    cyc();
    check("oe_rst", pin_oe_n, 3'h7);
    check("pin_rst", pin_out, port_out);
    rd(ADDR_CTRL, d);
    check("ctrl_rst", d, 16'h0000);
    rd(ADDR_FLAGS, d);
    check("flags_rst", d, 16'h0000);
    wr(16'h0002, 16'hFFFF);
    rd(16'h0002, d);
    check("unmapped", d, 16'h0000);
    wr(ADDR_CMP_A, 16'h0020);
    // table rows: top per mode, slope shape, flags, write masking
    foreach (ROWS[i]) begin
      wr(ADDR_CAP, ROWS[i].cap);
      wr(ADDR_CTRL, cw(COM_OFF, COM_OFF, COM_OFF, PRE_DIV1, ROWS[i].m));
      wr(ADDR_CNT, 16'h0000);
      wr(ADDR_CMP_B, 16'hFFFF);
      rd(ADDR_CMP_B, d);
      check("cmp_mask", d, ROWS[i].mask);
      wr(ADDR_FLAGS, 16'h001F);
      mx = 16'h0000;
      bad = 0;
      cyc();
      prev = count_value;
      repeat (4 * int'(ROWS[i].top) + 40) begin
        cyc();
        dif = count_value - prev;
        if (dif !== 16'h0001 && dif !== 16'hFFFF) bad++;
        if (count_value > mx) mx = count_value;
        prev = count_value;
      end
      check("top", mx, ROWS[i].top);
      check("slope", bad[15:0], 16'h0000);
      check("ovf", overflow_flag, 1'h1);
      check("cap_f", capture_flag, ROWS[i].fc);
      check("cmp_f", compare_flag[0], ROWS[i].fa);
    end
    // set and clear on the two slopes, both polarities, pin muxing
    wr(ADDR_CMP_A, 16'h0004);
    wr(ADDR_CMP_B, 16'h0004);
    wr(ADDR_CAP, 16'h0010);
    wr(ADDR_CTRL, cw(COM_NONINV, COM_INV, COM_TOGGLE, PRE_DIV1, WGM_PC_CAP));
    wr(ADDR_CNT, 16'h0000);
    wr(ADDR_DIR, 16'h0003);
    repeat (80) cyc();
    repeat (64) begin
      cyc();
      if (count_value === 16'h0010) begin
        check("a_top", compare_output[0], 1'h0);
        check("b_top", compare_output[1], 1'h1);
      end
      if (count_value === 16'h0000) begin
        check("a_bot", compare_output[0], 1'h1);
        check("b_bot", compare_output[1], 1'h0);
        check("pin_ab", pin_out[1:0], 2'h1);
        check("pin_c", pin_out[2], port_out[2]);
        check("oe", pin_oe_n, 3'h4);
      end
    end
    // extreme duty: compare at top non-inverted, at bottom inverted
    wr(ADDR_CMP_A, 16'h0010);
    wr(ADDR_CMP_B, 16'h0000);
    repeat (80) cyc();
    hi_a = 0;
    hi_b = 0;
    repeat (64) begin
      cyc();
      hi_a += int'(compare_output[0]);
      hi_b += int'(compare_output[1]);
    end
    check("hi_a", hi_a[15:0], 16'h0040);
    check("hi_b", hi_b[15:0], 16'h0040);
    wr(ADDR_DIR, 16'h0000);
    wr(ADDR_CTRL, cw(COM_OFF, COM_TOGGLE, COM_OFF, PRE_DIV1, WGM_PC_CAP));
    port_out <= 3'h2;
    cyc();
    check("oe_off", pin_oe_n, 3'h7);
    check("pin_port", pin_out, 3'h2);
    // half-duty toggle with compare a as top; period 32 cycles
    wr(ADDR_CMP_A, 16'h0008);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, cw(COM_TOGGLE, COM_OFF, COM_OFF, PRE_DIV1,
                       (k == 0) ? WGM_PC_CMA : WGM_PFC_CMA));
      repeat (80) cyc();
      hi_a = 0;
      repeat (64) begin
        cyc();
        hi_a += int'(compare_output[0]);
      end
      check("toggle", hi_a[15:0], 16'h0020);
      check("pin_tog", pin_out[0], compare_output[0]);
    end
    // prescaler: ticks per 2048 cycles, count moves only after a tick
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_CTRL, cw(COM_OFF, COM_OFF, COM_OFF, s[2:0], WGM_PC10));
      cyc();
      tk = 0;
      bad = 0;
      prev = count_value;
      ptk = timer_tick;
      repeat (2048) begin
        cyc();
        if ((count_value !== prev) !== ptk) bad++;
        tk += int'(timer_tick);
        prev = count_value;
        ptk = timer_tick;
      end
      check("ticks", tk[15:0], TICKS[s][15:0]);
      check("gated", bad[15:0], 16'h0000);
    end
    // reset in mid-run clears counter, flags and outputs
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    cyc();
    check("cnt_rst", count_value, 16'h0000);
    d = {11'h000, compare_flag, capture_flag, overflow_flag};
    check("flg_rst", d, 16'h0000);
    check("oc_rst", compare_output, 3'h0);
    check("oe_rst2", pin_oe_n, 3'h7);
    summarize();
  end
endmodule : dsp_timer_bench
`default_nettype wire
